// File: hw/stfb_regs.svh
`ifndef STFB_REGS_SVH
`define STFB_REGS_SVH

// ----------------------------------------
// defined bit masks, preset values
// ----------------------------------------
`define STFB_OPERATION_SUMMARY_MASK   16'h0521
`define STFB_QUESTIONABLE_SUMMARY_MASK   16'h0613
`define STFB_OPERATION_SUMMARY_PRESET 16'h0521
`define STFB_QUESTIONABLE_SUMMARY_PRESET 16'h0613
`define STFB_REG_RESET   16'h0000
`define STFB_WR_MAX      16'h7fd7

// ----------------------------------------
// status byte positions, error codes
// ----------------------------------------
`define STFB_STB_QUESTIONABLE_SUMMARY    3
`define STFB_STB_OPERATION_SUMMARY    7
`define STFB_ERR_NONE    16'h0000
`define STFB_ERR_OVF     16'hfea2
`define STFB_ERR_RANGE   16'hff22
`define STFB_VERS_YEAR   16'h07cb
`define STFB_VERS_REV    4'h0

`endif

// File: hw/stfb_pkg.sv
package stfb_pkg;

  // ----------------------------------------
  // remote command codes
  // ----------------------------------------
  typedef enum logic [4:0] {
    STFB_NOP      = 5'h00,
    STFB_OP_EV_RD = 5'h01,
    STFB_OP_CO_RD = 5'h02,
    STFB_OP_EN_WR = 5'h03,
    STFB_OP_EN_RD = 5'h04,
    STFB_OP_FA_WR = 5'h05,
    STFB_OP_FA_RD = 5'h06,
    STFB_OP_RI_WR = 5'h07,
    STFB_OP_RI_RD = 5'h08,
    STFB_QU_EV_RD = 5'h09,
    STFB_QU_CO_RD = 5'h0a,
    STFB_QU_EN_WR = 5'h0b,
    STFB_QU_EN_RD = 5'h0c,
    STFB_QU_FA_WR = 5'h0d,
    STFB_QU_FA_RD = 5'h0e,
    STFB_QU_RI_WR = 5'h0f,
    STFB_QU_RI_RD = 5'h10,
    STFB_PRESET   = 5'h11,
    STFB_ERR_RD   = 5'h12,
    STFB_LANG_WR  = 5'h13,
    STFB_LANG_RD  = 5'h14,
    STFB_VERS_RD  = 5'h15
  } stfb_cmd_t;

  // ----------------------------------------
  // one status group
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [15:0] prev;
    logic [15:0] fall;
    logic [15:0] rise;
    logic [15:0] en;
    logic [15:0] ev;
  } stfb_grp_t;

endpackage

// File: hw/stfb_bank.sv
`timescale 1ns/100ps
`include "stfb_regs.svh"

module stfb_bank #(
  parameter int ERR_DEPTH = 8
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst,
  // live status pins
  input  wire logic [15:0]       i_operation_summary_cond,
  input  wire logic [15:0]       i_questionable_summary_cond,
  // remote command
  input  wire stfb_pkg::stfb_cmd_t i_cmd,
  input  wire logic [15:0]       i_cmd_data,
  // error reports
  input  wire logic              i_err_valid,
  input  wire logic [15:0]       i_err_code,
  input  wire logic              i_err_local,
  // stored language
  input  wire logic              i_nv_lang,
  // answers
  output logic                   o_rsp_valid,
  output logic [15:0]            o_rsp_data,
  output logic [3:0]             o_rsp_aux,
  // status and language
  output logic [7:0]             o_status_byte,
  output logic                   o_lang,
  output logic                   o_nv_store,
  output logic                   o_recall0
);

  localparam int PW = (ERR_DEPTH > 1) ? $clog2(ERR_DEPTH) : 1;
  localparam int CW = $clog2(ERR_DEPTH + 1);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // a single slot could not hold an entry beside the overflow marker
  if (ERR_DEPTH < 2) begin : g_chk
    $error("ERR_DEPTH must be at least 2");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    stfb_pkg::stfb_grp_t             op;
    stfb_pkg::stfb_grp_t             qu;
    logic [ERR_DEPTH-1:0][15:0]      q;
    logic [PW-1:0]                   rp;
    logic [CW-1:0]                   cnt;
    logic                            lang;
    logic                            lang_ok;
    logic                            nv_we;
    logic                            rcl;
    logic                            rsp_v;
    logic [15:0]                     rsp_d;
    logic [3:0]                      rsp_x;
    logic [7:0]                      stb;
  } stfb_state_t;

  stfb_state_t r;
  stfb_state_t nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // ring index a given distance after the read pointer
  // wraps by subtraction, so the depth need not be a power of two
  function automatic logic [PW-1:0] ring(input logic [PW-1:0] base, input logic [CW-1:0] off);
    int s;
    s = int'(base) + int'(off);
    if (s >= ERR_DEPTH) begin
      s = s - ERR_DEPTH;
    end
    return PW'(s);
  endfunction

  // filtered transitions, plus events raised by newly set filter bits
  // a filter bit turning on while its condition already sits at the
  // watched level counts as a transition; preset writes count too
  function automatic logic [15:0] trans(input logic [15:0] cur, input logic [15:0] prv,
                                        input logic [15:0] fa, input logic [15:0] ri,
                                        input logic [15:0] fa_o, input logic [15:0] ri_o);
    logic [15:0] dn;
    logic [15:0] up;
    dn = prv & ~cur & fa;
    up = ~prv & cur & ri;
    return dn | up | (fa & ~fa_o & ~cur) | (ri & ~ri_o & cur);
  endfunction

  // write value within the accepted range
  function automatic logic in_range(input logic [15:0] v);
    return v <= `STFB_WR_MAX;
  endfunction

  // commands that return an answer; unknown codes stay silent
  function automatic logic is_query(input stfb_pkg::stfb_cmd_t c);
    return c inside {stfb_pkg::STFB_OP_EV_RD, stfb_pkg::STFB_OP_CO_RD, stfb_pkg::STFB_OP_EN_RD,
                     stfb_pkg::STFB_OP_FA_RD, stfb_pkg::STFB_OP_RI_RD, stfb_pkg::STFB_QU_EV_RD,
                     stfb_pkg::STFB_QU_CO_RD, stfb_pkg::STFB_QU_EN_RD, stfb_pkg::STFB_QU_FA_RD,
                     stfb_pkg::STFB_QU_RI_RD, stfb_pkg::STFB_ERR_RD, stfb_pkg::STFB_LANG_RD,
                     stfb_pkg::STFB_VERS_RD};
  endfunction

  // filter and enable writes, the ones checked against the range
  function automatic logic is_write(input stfb_pkg::stfb_cmd_t c);
    return c inside {stfb_pkg::STFB_OP_EN_WR, stfb_pkg::STFB_OP_FA_WR, stfb_pkg::STFB_OP_RI_WR,
                     stfb_pkg::STFB_QU_EN_WR, stfb_pkg::STFB_QU_FA_WR, stfb_pkg::STFB_QU_RI_WR};
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic        wr;
    logic        bad;
    logic        pop;
    logic [1:0]  pv;
    logic [15:0] pc [2];
    logic [CW-1:0] ca;
    logic [15:0] oc;
    logic [15:0] qc;
    logic [15:0] oev;
    logic [15:0] qev;
    nxt = r;
    wr = 1'b0;
    bad = 1'b0;
    pop = 1'b0;
    pv = 2'b00;
    pc[0] = i_err_code;
    pc[1] = `STFB_ERR_RANGE;
    ca = r.cnt;
    oev = 16'h0000;
    qev = 16'h0000;
    nxt.rsp_v = 1'b0;
    nxt.rsp_d = `STFB_ERR_NONE;
    nxt.rsp_x = 4'h0;
    nxt.nv_we = 1'b0;
    nxt.rcl = 1'b0;

    // pin synchronisers, then defined-bit masking
    // two flops on every status pin before any logic reads it
    nxt.op.sync1 = i_operation_summary_cond;
    nxt.qu.sync1 = i_questionable_summary_cond;
    nxt.op.sync2 = r.op.sync1;
    nxt.qu.sync2 = r.qu.sync1;
    oc = r.op.sync2 & `STFB_OPERATION_SUMMARY_MASK;
    qc = r.qu.sync2 & `STFB_QUESTIONABLE_SUMMARY_MASK;
    nxt.op.prev = oc;
    nxt.qu.prev = qc;

    // strapped language caught once after reset
    // later switches overwrite it, the stored copy is read only once
    if (!r.lang_ok) begin
      nxt.lang = i_nv_lang;
      nxt.lang_ok = 1'b1;
    end

    // command decode; only queries answer, unknown codes are ignored
    wr = is_write(i_cmd);
    bad = wr && !in_range(i_cmd_data);
    nxt.rsp_v = is_query(i_cmd);
    unique case (i_cmd)
      // register and condition queries
      stfb_pkg::STFB_OP_EV_RD: nxt.rsp_d = r.op.ev;
      stfb_pkg::STFB_OP_CO_RD: nxt.rsp_d = oc;
      stfb_pkg::STFB_OP_EN_RD: nxt.rsp_d = r.op.en;
      stfb_pkg::STFB_OP_FA_RD: nxt.rsp_d = r.op.fall;
      stfb_pkg::STFB_OP_RI_RD: nxt.rsp_d = r.op.rise;
      stfb_pkg::STFB_QU_EV_RD: nxt.rsp_d = r.qu.ev;
      stfb_pkg::STFB_QU_CO_RD: nxt.rsp_d = qc;
      stfb_pkg::STFB_QU_EN_RD: nxt.rsp_d = r.qu.en;
      stfb_pkg::STFB_QU_FA_RD: nxt.rsp_d = r.qu.fall;
      stfb_pkg::STFB_QU_RI_RD: nxt.rsp_d = r.qu.rise;
      // filter and enable writes, dropped when out of range
      stfb_pkg::STFB_OP_EN_WR: if (!bad) nxt.op.en = i_cmd_data;
      stfb_pkg::STFB_OP_FA_WR: if (!bad) nxt.op.fall = i_cmd_data;
      stfb_pkg::STFB_OP_RI_WR: if (!bad) nxt.op.rise = i_cmd_data;
      stfb_pkg::STFB_QU_EN_WR: if (!bad) nxt.qu.en = i_cmd_data;
      stfb_pkg::STFB_QU_FA_WR: if (!bad) nxt.qu.fall = i_cmd_data;
      stfb_pkg::STFB_QU_RI_WR: if (!bad) nxt.qu.rise = i_cmd_data;
      // preset, error queue, language and version
      stfb_pkg::STFB_PRESET: begin
        nxt.op.fall = `STFB_REG_RESET;
        nxt.qu.fall = `STFB_REG_RESET;
        nxt.op.en = `STFB_REG_RESET;
        nxt.qu.en = `STFB_REG_RESET;
        nxt.op.rise = `STFB_OPERATION_SUMMARY_PRESET;
        nxt.qu.rise = `STFB_QUESTIONABLE_SUMMARY_PRESET;
      end
      stfb_pkg::STFB_ERR_RD: begin
        if (r.cnt != '0) begin
          nxt.rsp_d = r.q[r.rp];
          pop = 1'b1;
        end else begin
          nxt.rsp_d = `STFB_ERR_NONE;
        end
      end
      stfb_pkg::STFB_LANG_WR: begin
        nxt.lang = i_cmd_data[0];
        nxt.lang_ok = 1'b1;
        nxt.nv_we = 1'b1;
        nxt.rcl = 1'b1;
      end
      stfb_pkg::STFB_LANG_RD: nxt.rsp_d = {15'h0000, r.lang};
      stfb_pkg::STFB_VERS_RD: begin
        nxt.rsp_d = `STFB_VERS_YEAR;
        nxt.rsp_x = `STFB_VERS_REV;
      end
      default: ;
    endcase

    // filtered transitions of both groups, next-cycle filters included
    oev = trans(oc, r.op.prev, nxt.op.fall, nxt.op.rise, r.op.fall, r.op.rise);
    qev = trans(qc, r.qu.prev, nxt.qu.fall, nxt.qu.rise, r.qu.fall, r.qu.rise);
    // unused positions never latch, not even through a filter write
    oev = oev & `STFB_OPERATION_SUMMARY_MASK;
    qev = qev & `STFB_QUESTIONABLE_SUMMARY_MASK;
    // events: read clears, a new event in the same cycle wins
    nxt.op.ev = ((i_cmd == stfb_pkg::STFB_OP_EV_RD) ? 16'h0000 : r.op.ev) | oev;
    nxt.qu.ev = ((i_cmd == stfb_pkg::STFB_QU_EV_RD) ? 16'h0000 : r.qu.ev) | qev;

    // summary bits of the status byte
    // built from next-state events so the byte never lags the registers
    nxt.stb = 8'h00;
    nxt.stb[`STFB_STB_QUESTIONABLE_SUMMARY] = |(nxt.qu.ev & nxt.qu.en);
    nxt.stb[`STFB_STB_OPERATION_SUMMARY] = |(nxt.op.ev & nxt.op.en);

    // error queue: pop first, then up to two pushes
    // range error goes in after the external one; a full queue keeps its count
    if (pop) begin
      nxt.rp = ring(r.rp, CW'(1));
      ca = r.cnt - CW'(1);
    end
    pv[0] = i_err_valid && !i_err_local;
    pv[1] = bad;
    for (int k = 0; k < 2; k++) begin
      if (pv[k]) begin
        if (ca < CW'(ERR_DEPTH)) begin
          nxt.q[ring(nxt.rp, ca)] = pc[k];
          ca = ca + CW'(1);
        end else begin
          nxt.q[ring(nxt.rp, CW'(ERR_DEPTH - 1))] = `STFB_ERR_OVF;
        end
      end
    end
    nxt.cnt = ca;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // whole state in one register; reset leaves filters and enables at zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output straight from the state register
  assign o_rsp_valid   = r.rsp_v;
  assign o_rsp_data    = r.rsp_d;
  assign o_rsp_aux     = r.rsp_x;
  assign o_status_byte = r.stb;
  assign o_lang        = r.lang;
  assign o_nv_store    = r.nv_we;
  assign o_recall0     = r.rcl;

endmodule

// File: sim/stfb_checker.sv
`timescale 1ns/100ps
`include "stfb_regs.svh"

// ----------------------------------------
// port checker
// ----------------------------------------
module stfb_checker (
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  // command and answers
  input  wire stfb_pkg::stfb_cmd_t i_cmd,
  input  wire logic [15:0]         i_cmd_data,
  input  wire logic                o_rsp_valid,
  input  wire logic [15:0]         o_rsp_data,
  input  wire logic [3:0]          o_rsp_aux,
  input  wire logic [7:0]          o_status_byte,
  input  wire logic                o_lang,
  input  wire logic                o_nv_store,
  input  wire logic                o_recall0
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // query commands that must be answered
  logic qry;
  assign qry = i_cmd inside {5'h01, 5'h02, 5'h04, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14, 5'h15};

  // answer timing and content
  chk_query_answer: assert property (qry |=> o_rsp_valid) else $error("query not answered");
  chk_no_spurious: assert property (!qry |=> !o_rsp_valid) else $error("answer without query");
  chk_version_word: assert property (i_cmd == 5'h15 |=>
    o_rsp_data == `STFB_VERS_YEAR && o_rsp_aux == `STFB_VERS_REV) else $error("bad version answer");
  chk_aux_idle: assert property (i_cmd != 5'h15 |=> o_rsp_aux == 4'h0) else $error("aux not zero");
  chk_questionable_summary_cond_mask: assert property (i_cmd == 5'h0a |=> (o_rsp_data & ~`STFB_QUESTIONABLE_SUMMARY_MASK) == 16'h0000)
    else $error("unused questionable bit set");
  chk_operation_summary_cond_mask: assert property (i_cmd == 5'h02 |=> (o_rsp_data & ~`STFB_OPERATION_SUMMARY_MASK) == 16'h0000)
    else $error("unused operation bit set");
  chk_status_unused: assert property ((o_status_byte & 8'h77) == 8'h00) else $error("unused status bit set");
  chk_lang_switch: assert property (i_cmd == 5'h13 |=>
    o_nv_store && o_recall0 && o_lang == $past(i_cmd_data[0])) else $error("language switch not carried out");
  chk_recall_store: assert property (o_recall0 == o_nv_store) else $error("recall apart from store");
  chk_store_idle: assert property (i_cmd != 5'h13 |=> !o_nv_store) else $error("store without switch");

  // main scenarios
  cov_version: cover property (i_cmd == 5'h15 ##1 o_rsp_valid);
  cov_lang: cover property (o_nv_store);
  cov_questionable_summary_sum: cover property (o_status_byte[`STFB_STB_QUESTIONABLE_SUMMARY]);
  cov_operation_summary_sum: cover property (o_status_byte[`STFB_STB_OPERATION_SUMMARY]);
endmodule

bind stfb_bank stfb_checker u_stfb_checker (.i_ref_clk, .i_rst, .i_cmd, .i_cmd_data, .o_rsp_valid, .o_rsp_data,
  .o_rsp_aux, .o_status_byte, .o_lang, .o_nv_store, .o_recall0);

// File: sim/tb.sv
`timescale 1ns/100ps
`include "stfb_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module tb;
  // design signals
  logic                i_ref_clk, i_rst, i_err_valid, i_err_local, i_nv_lang;
  logic                o_rsp_valid, o_lang, o_nv_store, o_recall0;
  logic [15:0]         i_operation_summary_cond, i_questionable_summary_cond, i_cmd_data, i_err_code, o_rsp_data;
  logic [3:0]          o_rsp_aux;
  logic [7:0]          o_status_byte;
  stfb_pkg::stfb_cmd_t i_cmd;
  int                  n_fail, check_count;
  // filter and enable read commands
  stfb_pkg::stfb_cmd_t u_rd[6] = '{stfb_pkg::STFB_OP_EN_RD, stfb_pkg::STFB_OP_FA_RD, stfb_pkg::STFB_OP_RI_RD,
                                   stfb_pkg::STFB_QU_EN_RD, stfb_pkg::STFB_QU_FA_RD, stfb_pkg::STFB_QU_RI_RD};

  // design with a two-entry error queue
  stfb_bank #(.ERR_DEPTH(2)) u_stfb_bank (.i_ref_clk, .i_rst, .i_operation_summary_cond, .i_questionable_summary_cond, .i_cmd, .i_cmd_data,
    .i_err_valid, .i_err_code, .i_err_local, .i_nv_lang, .o_rsp_valid, .o_rsp_data, .o_rsp_aux, .o_status_byte,
    .o_lang, .o_nv_store, .o_recall0);

  // 40 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic w(input stfb_pkg::stfb_cmd_t c, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_cmd <= c;
    i_cmd_data <= d;
    @(posedge i_ref_clk);
    i_cmd <= stfb_pkg::STFB_NOP;
  endtask

  task automatic q(input stfb_pkg::stfb_cmd_t c, input logic [15:0] e);
    w(c, 16'h0000);
    #1;
    `CHK(o_rsp_valid, 1'b1)
    `CHK(o_rsp_data, e)
  endtask

  task automatic pin(input logic [15:0] v);
    @(posedge i_ref_clk);
    i_questionable_summary_cond <= v;
    repeat (5) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic err(input logic [15:0] c, input logic l);
    @(posedge i_ref_clk);
    i_err_valid <= 1'b1;
    i_err_code <= c;
    i_err_local <= l;
    @(posedge i_ref_clk);
    i_err_valid <= 1'b0;
  endtask

  task automatic results;
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (4000) @(posedge i_ref_clk);
    n_fail++;
    results;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {i_rst, i_nv_lang} = 2'b11;
    {i_err_valid, i_err_local, i_err_code, i_cmd_data, i_operation_summary_cond, i_questionable_summary_cond} = '0;
    i_cmd = stfb_pkg::STFB_NOP;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK(o_lang, 1'b1)
    // register defaults, write limit
    foreach (u_rd[k]) q(u_rd[k], `STFB_REG_RESET);
    w(stfb_pkg::STFB_QU_EN_WR, `STFB_WR_MAX);
    w(stfb_pkg::STFB_QU_EN_WR, 16'h7fd8);
    q(stfb_pkg::STFB_QU_EN_RD, `STFB_WR_MAX);
    q(stfb_pkg::STFB_ERR_RD, `STFB_ERR_RANGE);
    q(stfb_pkg::STFB_ERR_RD, `STFB_ERR_NONE);
    // live conditions
    @(posedge i_ref_clk) i_operation_summary_cond <= 16'hffff;
    pin(16'hffff);
    q(stfb_pkg::STFB_QU_CO_RD, `STFB_QUESTIONABLE_SUMMARY_MASK);
    q(stfb_pkg::STFB_OP_CO_RD, `STFB_OPERATION_SUMMARY_MASK);
    q(stfb_pkg::STFB_OP_EV_RD, 16'h0000);
    pin(16'h0000);
    // transition filters on the overtemperature bit
    w(stfb_pkg::STFB_QU_EN_WR, 16'h0010);
    w(stfb_pkg::STFB_QU_RI_WR, 16'h0010);
    pin(16'h0010);
    `CHK(o_status_byte, 8'h08)
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0010);
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0000);
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK(o_status_byte, 8'h00)
    w(stfb_pkg::STFB_QU_RI_WR, 16'h0000);
    w(stfb_pkg::STFB_QU_FA_WR, 16'h0010);
    pin(16'h0000);
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0010);
    pin(16'h0010);
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0000);
    w(stfb_pkg::STFB_QU_RI_WR, 16'h0010);
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0010);
    pin(16'h0000);
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0010);
    pin(16'h0010);
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0010);
    w(stfb_pkg::STFB_QU_RI_WR, 16'h0000);
    w(stfb_pkg::STFB_QU_FA_WR, 16'h0000);
    pin(16'h0000);
    q(stfb_pkg::STFB_QU_EV_RD, 16'h0000);
    // operation summary on the trigger wait bit
    @(posedge i_ref_clk) i_operation_summary_cond <= 16'h0000;
    w(stfb_pkg::STFB_OP_EN_WR, 16'h0020);
    w(stfb_pkg::STFB_OP_RI_WR, 16'h0020);
    i_operation_summary_cond <= 16'h0020;
    pin(16'h0000);
    `CHK(o_status_byte, 8'h80)
    q(stfb_pkg::STFB_OP_EV_RD, 16'h0020);
    // error queue order, overflow, local drop
    err(16'hff9c, 1'b0);
    err(16'hff9b, 1'b1);
    err(16'hff9a, 1'b0);
    err(16'hff99, 1'b0);
    q(stfb_pkg::STFB_ERR_RD, 16'hff9c);
    q(stfb_pkg::STFB_ERR_RD, `STFB_ERR_OVF);
    q(stfb_pkg::STFB_ERR_RD, `STFB_ERR_NONE);
    // preset, version, language
    w(stfb_pkg::STFB_PRESET, 16'h0000);
    q(stfb_pkg::STFB_OP_RI_RD, 16'h0521);
    q(stfb_pkg::STFB_QU_RI_RD, 16'h0613);
    q(stfb_pkg::STFB_OP_EN_RD, 16'h0000);
    q(stfb_pkg::STFB_QU_FA_RD, 16'h0000);
    // falling filter set while the calibration and current bits sit low
    w(stfb_pkg::STFB_OP_FA_WR, 16'h4400);
    q(stfb_pkg::STFB_OP_FA_RD, 16'h4400);
    q(stfb_pkg::STFB_OP_EV_RD, 16'h0400);
    q(stfb_pkg::STFB_VERS_RD, `STFB_VERS_YEAR);
    `CHK(o_rsp_aux, `STFB_VERS_REV)
    w(stfb_pkg::STFB_LANG_WR, 16'h0000);
    #1;
    `CHK({o_lang, o_nv_store, o_recall0}, 3'b011)
    @(posedge i_ref_clk);
    #1;
    `CHK({o_nv_store, o_recall0}, 2'b00)
    q(stfb_pkg::STFB_LANG_RD, 16'h0000);
    results;
  end
endmodule
